// ---- core/ctrl_pkg.sv ----
// constants for the two-wire controller enable, abort and status slice
package ctrl_pkg;
   // register byte addresses
   localparam logic [31:0] STOP_CLR_ADDR = 32'h5000_1360;
   localparam logic [31:0] START_CLR_ADDR = 32'h5000_1364;
   localparam logic [31:0] GCALL_CLR_ADDR = 32'h5000_1368;
   localparam logic [31:0] ENABLE_ADDR = 32'h5000_136C;
   localparam logic [31:0] STATUS_ADDR = 32'h5000_1370;
   localparam logic [31:0] TXABRT_CLR_ADDR = 32'h5000_1354;
   // raw interrupt status positions
   localparam int TX_ABRT_BIT = 6;
   localparam int STOP_BIT = 9;
   localparam int START_BIT = 10;
   localparam int GCALL_BIT = 11;
   localparam int RAW_W = 12;
   // enable register fields
   localparam int EN_BIT = 0;
   localparam int ABORT_BIT = 1;
   localparam logic EN_RST = 1'h0;
   localparam logic ABORT_RST = 1'h0;
   // status register fields
   localparam int ST_ACT_BIT = 0;
   localparam int ST_TX_NOT_FULL_BIT = 1;
   localparam int ST_TX_EMPTY_BIT = 2;
   localparam int ST_RX_NOT_EMPTY_BIT = 3;
   localparam int ST_RX_FULL_BIT = 4;
   localparam int ST_MST_BIT = 5;
   localparam int ST_SLV_BIT = 6;
   // fifo geometry and level width
   localparam int LVL_W = 6;
   localparam logic [5:0] FIFO_DEPTH = 6'h20;
   localparam int DATA_W = 16;
   // enable takes effect this many clocks after the register
   localparam int EN_DELAY = 2;
   typedef enum logic [1:0]
   {
      AB_IDLE = 2'b00,
      AB_WAIT = 2'b01,
      AB_STOP = 2'b10,
      AB_DONE = 2'b11
   } abort_t;
endpackage

// ---- core/ctrl_slice.sv ----
// enable, abort, stop/start/general-call clear and status logic of the two-wire controller
//
// Operation
// - reading the stop clear register clears raw stop bit 9
// - reading the start clear register clears raw start bit 10
// - reading the general-call clear register clears raw bit 11
// - abort write ignored unless controller enable already set
// - software cannot clear abort once set
// - abort finishes transfer, issues STOP, flushes transmit fifo, raises transmit abort
// - hardware clears abort when abort completes
// - abort reads 1 during abort, otherwise 0; resets to 0
// - enable bit 0 resets 0; while 0 both fifos held erased (here the transmit fifo only once master not busy)
// - masked interrupt bits stay active after disable until idle
// - disabled while transmitting: finish transfer, stop, discard transmit data
// - disabled while receiving: stop after current byte, no acknowledge
// - enable and disable take effect two clocks later
// - status bit 6 shows slave state machine busy
// - status bit 5 shows master state machine busy
// - status bit 4 shows receive fifo full; resets 0
// - status bit 3 shows receive fifo not empty
// - status bit 2 shows transmit fifo empty; resets 1; no interrupt
// - status bit 1 shows transmit fifo not full; resets 1
// - transmit abort clear read clears bit 6, source, releases fifo
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/100ps
module ctrl_slice
(
   // clock and reset
   input wire logic CLK,
   input wire logic RESETN,
   // register port
   input wire logic [31:0] ADDR,
   input wire logic [15:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [15:0] RDATA,
   // two-wire bus pins, observed only
   input wire logic SCL_IN,
   input wire logic SDA_IN,
   // state from the rest of the unit
   input wire logic MASTER_BUSY,
   input wire logic SLAVE_BUSY,
   input wire logic RECEIVING,
   input wire logic BYTE_DONE,
   input wire logic BROADCAST_CALL_SET,
   input wire logic [5:0] TX_LEVEL,
   input wire logic [5:0] RX_LEVEL,
   input wire logic [11:0] INTR_MASK,
   // controls to the rest of the unit
   output logic CTRL_ENABLED,
   output logic STOP_REQ,
   output logic RX_NACK,
   output logic TX_FLUSH,
   output logic RX_FLUSH,
   output logic ABORT_SRC_CLEAR,
   output logic [11:0] RAW_STATUS,
   output logic [11:0] MASKED_STATUS
);
   logic scl_s1_q, scl_s2_q, scl_s3_q;
   logic sda_s1_q, sda_s2_q, sda_s3_q;
   logic bus_start, bus_stop;
   logic en_q, en_p1_q, abort_q;
   logic [11:0] raw_q, raw_d;
   logic rd_stop, rd_start, rd_gcall, rd_txabrt, wr_en;
   logic txabrt_hold_q, dis_stop_q;
   logic [15:0] rdata_d, status_v;
   ctrl_pkg::abort_t ab_q, ab_d;

   // pins cross into CLK through two flops; the third only remembers the old level for edges
   always_ff @(posedge CLK)
   begin
      if (!RESETN)
      begin
         scl_s1_q <= 1'h1;
         scl_s2_q <= 1'h1;
         scl_s3_q <= 1'h1;
         sda_s1_q <= 1'h1;
         sda_s2_q <= 1'h1;
         sda_s3_q <= 1'h1;
      end
      else
      begin
         scl_s1_q <= SCL_IN;
         scl_s2_q <= scl_s1_q;
         scl_s3_q <= scl_s2_q;
         sda_s1_q <= SDA_IN;
         sda_s2_q <= sda_s1_q;
         sda_s3_q <= sda_s2_q;
      end
   end

   assign bus_start = scl_s2_q && scl_s3_q && sda_s3_q && !sda_s2_q;
   assign bus_stop = scl_s2_q && scl_s3_q && !sda_s3_q && sda_s2_q;

   assign rd_stop = RD && (ADDR == ctrl_pkg::STOP_CLR_ADDR);
   assign rd_start = RD && (ADDR == ctrl_pkg::START_CLR_ADDR);
   assign rd_gcall = RD && (ADDR == ctrl_pkg::GCALL_CLR_ADDR);
   assign rd_txabrt = RD && (ADDR == ctrl_pkg::TXABRT_CLR_ADDR);
   assign wr_en = WR && (ADDR == ctrl_pkg::ENABLE_ADDR);

   // enable register; the unit sees it two clocks later
   always_ff @(posedge CLK)
   begin
      if (!RESETN)
      begin
         en_q <= ctrl_pkg::EN_RST;
         en_p1_q <= ctrl_pkg::EN_RST;
         CTRL_ENABLED <= ctrl_pkg::EN_RST;
      end
      else
      begin
         if (wr_en)
         begin
            en_q <= WDATA[ctrl_pkg::EN_BIT];
         end
         en_p1_q <= en_q;
         CTRL_ENABLED <= en_p1_q;
      end
   end

   // abort bit: only software sets it, only the sequencer clears it; a set wins a same-cycle clear
   always_ff @(posedge CLK)
   begin
      if (!RESETN)
      begin
         abort_q <= ctrl_pkg::ABORT_RST;
      end
      else if (wr_en && WDATA[ctrl_pkg::ABORT_BIT] && en_q)
      begin
         abort_q <= 1'h1;
      end
      else if (ab_q == ctrl_pkg::AB_DONE)
      begin
         // self clear; zero writes never land here
         abort_q <= 1'h0;
      end
   end

   // abort sequence: let the byte finish, stop the bus, then flush
   always_comb
   begin
      ab_d = ab_q;
      unique case (ab_q)
         ctrl_pkg::AB_IDLE:
         begin
            if (abort_q)
            begin
               ab_d = ctrl_pkg::AB_WAIT;
            end
         end
         ctrl_pkg::AB_WAIT:
         begin
            if (BYTE_DONE || !MASTER_BUSY)
            begin
               ab_d = ctrl_pkg::AB_STOP;
            end
         end
         ctrl_pkg::AB_STOP:
         begin
            if (bus_stop || !MASTER_BUSY)
            begin
               ab_d = ctrl_pkg::AB_DONE;
            end
         end
         ctrl_pkg::AB_DONE:
         begin
            ab_d = ctrl_pkg::AB_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK)
   begin
      if (!RESETN)
      begin
         ab_q <= ctrl_pkg::AB_IDLE;
      end
      else
      begin
         ab_q <= ab_d;
      end
   end

   // disable while busy: hold off the stop until the current byte ends
   always_ff @(posedge CLK)
   begin
      if (!RESETN)
      begin
         dis_stop_q <= 1'h0;
      end
      else if (CTRL_ENABLED || !MASTER_BUSY)
      begin
         dis_stop_q <= 1'h0;
      end
      else if (BYTE_DONE)
      begin
         dis_stop_q <= 1'h1;
      end
   end

   // transmit fifo stays flushed after an abort until software reads the abort clear
   always_ff @(posedge CLK)
   begin
      if (!RESETN)
      begin
         txabrt_hold_q <= 1'h0;
      end
      else if (ab_q == ctrl_pkg::AB_DONE)
      begin
         txabrt_hold_q <= 1'h1;
      end
      else if (rd_txabrt)
      begin
         txabrt_hold_q <= 1'h0;
      end
   end

   // sticky raw bits; hardware set beats the read clear in the same cycle
   always_comb
   begin
      raw_d = raw_q;
      raw_d[ctrl_pkg::STOP_BIT] = bus_stop || (raw_q[ctrl_pkg::STOP_BIT] && !rd_stop);
      raw_d[ctrl_pkg::START_BIT] = bus_start || (raw_q[ctrl_pkg::START_BIT] && !rd_start);
      raw_d[ctrl_pkg::GCALL_BIT] = BROADCAST_CALL_SET || (raw_q[ctrl_pkg::GCALL_BIT] && !rd_gcall);
      // transmit abort raised after abort, cleared on read
      raw_d[ctrl_pkg::TX_ABRT_BIT] = (ab_q == ctrl_pkg::AB_DONE) || (raw_q[ctrl_pkg::TX_ABRT_BIT] && !rd_txabrt);
   end

   always_ff @(posedge CLK)
   begin
      if (!RESETN)
      begin
         raw_q <= 12'h000;
      end
      else
      begin
         raw_q <= raw_d;
      end
   end

   // controls to the unit, all registered
   always_ff @(posedge CLK)
   begin
      if (!RESETN)
      begin
         STOP_REQ <= 1'h0;
         RX_NACK <= 1'h0;
         TX_FLUSH <= 1'h1;
         RX_FLUSH <= 1'h1;
         ABORT_SRC_CLEAR <= 1'h0;
         RAW_STATUS <= 12'h000;
         MASKED_STATUS <= 12'h000;
      end
      else
      begin
         STOP_REQ <= (ab_q == ctrl_pkg::AB_STOP) || dis_stop_q;
         // no acknowledge for the last byte
         RX_NACK <= !CTRL_ENABLED && RECEIVING;
         // flush from the abort's last cycle on, so no gap before the hold takes over
         TX_FLUSH <= (!CTRL_ENABLED && !MASTER_BUSY) || txabrt_hold_q || (ab_q == ctrl_pkg::AB_DONE);
         RX_FLUSH <= !CTRL_ENABLED;
         ABORT_SRC_CLEAR <= rd_txabrt;
         RAW_STATUS <= raw_q;
         // masked bits live on until disabled and idle
         MASKED_STATUS <= (CTRL_ENABLED || MASTER_BUSY || SLAVE_BUSY) ? (raw_q & INTR_MASK) : 12'h000;
      end
   end

   // status word; bit 2 is report only and feeds no interrupt
   always_comb
   begin
      status_v = 16'h0000;
      status_v[ctrl_pkg::ST_ACT_BIT] = MASTER_BUSY || SLAVE_BUSY;
      status_v[ctrl_pkg::ST_TX_NOT_FULL_BIT] = TX_LEVEL != ctrl_pkg::FIFO_DEPTH;
      status_v[ctrl_pkg::ST_TX_EMPTY_BIT] = TX_LEVEL == 6'h00;
      status_v[ctrl_pkg::ST_RX_NOT_EMPTY_BIT] = RX_LEVEL != 6'h00;
      status_v[ctrl_pkg::ST_RX_FULL_BIT] = RX_LEVEL == ctrl_pkg::FIFO_DEPTH;
      status_v[ctrl_pkg::ST_MST_BIT] = MASTER_BUSY;
      status_v[ctrl_pkg::ST_SLV_BIT] = SLAVE_BUSY;
   end

   always_comb
   begin
      rdata_d = 16'h0000;
      if (RD)
      begin
         unique case (ADDR)
            ctrl_pkg::STOP_CLR_ADDR: rdata_d[0] = raw_q[ctrl_pkg::STOP_BIT];
            ctrl_pkg::START_CLR_ADDR: rdata_d[0] = raw_q[ctrl_pkg::START_BIT];
            ctrl_pkg::GCALL_CLR_ADDR: rdata_d[0] = raw_q[ctrl_pkg::GCALL_BIT];
            ctrl_pkg::TXABRT_CLR_ADDR: rdata_d[0] = raw_q[ctrl_pkg::TX_ABRT_BIT];
            ctrl_pkg::ENABLE_ADDR:
            begin
               rdata_d[ctrl_pkg::EN_BIT] = en_q;
               rdata_d[ctrl_pkg::ABORT_BIT] = abort_q;
            end
            ctrl_pkg::STATUS_ADDR: rdata_d = status_v;
            default: rdata_d = 16'h0000;
         endcase
      end
   end

   // read data only in the cycle after the strobe
   always_ff @(posedge CLK)
   begin
      if (!RESETN)
      begin
         RDATA <= 16'h0000;
      end
      else
      begin
         RDATA <= rdata_d;
      end
   end

   stop_clear_a: assert property (@(posedge CLK) disable iff (!RESETN)
      rd_stop && !bus_stop |=> !raw_q[ctrl_pkg::STOP_BIT]) else $error("stop bit survived its clear read");
   start_clear_a: assert property (@(posedge CLK) disable iff (!RESETN)
      rd_start && !bus_start |=> !raw_q[ctrl_pkg::START_BIT]) else $error("start bit survived its clear read");
   gcall_clear_a: assert property (@(posedge CLK) disable iff (!RESETN)
      rd_gcall && !BROADCAST_CALL_SET |=> !raw_q[ctrl_pkg::GCALL_BIT]) else $error("general call bit not cleared");
   abort_gate_a: assert property (@(posedge CLK) disable iff (!RESETN)
      wr_en && !en_q && !abort_q |=> !abort_q) else $error("abort set while disabled");
   abort_hold_a: assert property (@(posedge CLK) disable iff (!RESETN)
      abort_q && ab_q != ctrl_pkg::AB_DONE |=> abort_q) else $error("abort cleared early");
   abort_done_a: assert property (@(posedge CLK) disable iff (!RESETN)
      ab_q == ctrl_pkg::AB_DONE && !wr_en |=> raw_q[ctrl_pkg::TX_ABRT_BIT] && !abort_q && TX_FLUSH)
      else $error("abort end not flagged");
   enable_delay_a: assert property (@(posedge CLK) disable iff (!RESETN)
      $rose(en_q) ##0 (RESETN [*2]) |-> ##1 CTRL_ENABLED) else $error("enable delay wrong");
   rx_erase_a: assert property (@(posedge CLK) disable iff (!RESETN)
      !CTRL_ENABLED |=> RX_FLUSH) else $error("rx fifo not erased when disabled");
   tx_empty_read_a: assert property (@(posedge CLK) disable iff (!RESETN)
      RD && ADDR == ctrl_pkg::STATUS_ADDR |=> RDATA[ctrl_pkg::ST_TX_EMPTY_BIT] == ($past(TX_LEVEL) == 6'h00))
      else $error("tx empty status wrong");
endmodule

// ---- tb/bus_party.sv ----
// behavioural other party on the two-wire bus, making start and stop conditions
`timescale 1ns/100ps
module bus_party
(
   // pulled-up bus lines, high whenever released
   output logic SCL,
   output logic SDA
);
   initial
   begin
      SCL = 1'b1;
      SDA = 1'b1;
   end
   // clock only moves inside a frame and rests released outside it
   task automatic send_start();
      SDA = 1'b0;
      #62.5 SCL = 1'b0;
      #62.5;
   endtask
   task automatic send_stop();
      SDA = 1'b0;
      #62.5 SCL = 1'b1;
      #62.5 SDA = 1'b1;
      #62.5;
   endtask
endmodule

// ---- tb/tb.sv ----
// self-checking bench for the enable, abort and status slice
`timescale 1ns/100ps
module tb;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [31:0] addr = 32'h0;
   logic [15:0] wdata = 16'h0;
   logic wr_s = 1'b0;
   logic rd_s = 1'b0;
   logic master_busy = 1'b0;
   logic slave_busy = 1'b0;
   logic receiving = 1'b0;
   logic byte_done = 1'b0;
   logic bcast = 1'b0;
   logic [5:0] tx_level = 6'h00;
   logic [5:0] rx_level = 6'h00;
   logic [11:0] intr_mask = 12'hFFF;
   logic [15:0] rdata, got;
   logic [11:0] raw, masked;
   logic scl, sda, enabled, stop_req, rx_nack, tx_flush, rx_flush, src_clear;
   logic [13:0] cases [5] = '{14'h0000, 14'h2082, 14'h0505, 14'h1F7F, 14'h0040};
   int miscompares = 0;
   int comparisons = 0;
   int n;
   ctrl_slice uut (.CLK(clk), .RESETN(resetn), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
      .RDATA(rdata), .SCL_IN(scl), .SDA_IN(sda), .MASTER_BUSY(master_busy), .SLAVE_BUSY(slave_busy),
      .RECEIVING(receiving), .BYTE_DONE(byte_done), .BROADCAST_CALL_SET(bcast), .TX_LEVEL(tx_level),
      .RX_LEVEL(rx_level), .INTR_MASK(intr_mask), .CTRL_ENABLED(enabled), .STOP_REQ(stop_req),
      .RX_NACK(rx_nack), .TX_FLUSH(tx_flush), .RX_FLUSH(rx_flush), .ABORT_SRC_CLEAR(src_clear),
      .RAW_STATUS(raw), .MASKED_STATUS(masked));
   bus_party u_bus (.SCL(scl), .SDA(sda));
   initial
   forever #2 clk = ~clk;
   task automatic report_and_stop();
      $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask
   task automatic limit(input int i);
      if (i >= 20)
      begin
         miscompares++;
         report_and_stop();
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [31:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
      #1;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [31:0] a);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1;
      got = rdata;
   endtask
   task automatic pulse_done();
      @(posedge clk);
      byte_done <= 1'b1;
      @(posedge clk);
      byte_done <= 1'b0;
      #1;
   endtask
   task automatic done(input string name);
      $display("end of test: %s", name);
   endtask
   function automatic logic [15:0] st_exp(input logic [13:0] c);
      return {9'h0, c[0], c[1], c[7:2] == 6'h20, c[7:2] != 6'h00, c[13:8] == 6'h00, c[13:8] != 6'h20, c[1] | c[0]};
   endfunction
   initial
   begin
      repeat (20000) @(posedge clk);
      miscompares++;
      report_and_stop();
   end
   initial
   begin
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      cyc(1);
      chk({tx_flush, rx_flush, enabled}, 3'b110);
      rd(ctrl_pkg::ENABLE_ADDR);
      chk(got, 16'h0000);
      rd(32'h5000_1380);
      chk(got, 16'h0000);
      for (int i = 0; i < 5; i++)
      begin
         @(posedge clk);
         {tx_level, rx_level, master_busy, slave_busy} <= cases[i];
         rd(ctrl_pkg::STATUS_ADDR);
         chk(got, st_exp(cases[i]));
      end
      {tx_level, rx_level, master_busy, slave_busy} <= 14'h0000;
      done("reset and status");
      wr(ctrl_pkg::ENABLE_ADDR, 16'h0002);
      rd(ctrl_pkg::ENABLE_ADDR);
      chk(got, 16'h0000);
      wr(ctrl_pkg::ENABLE_ADDR, 16'h0003);
      cyc(1);
      chk(enabled, 1'b0);
      cyc(1);
      chk(enabled, 1'b1);
      cyc(1);
      chk(rx_flush, 1'b0);
      rd(ctrl_pkg::ENABLE_ADDR);
      chk(got, 16'h0001);
      done("enable");
      @(posedge clk);
      master_busy <= 1'b1;
      wr(ctrl_pkg::ENABLE_ADDR, 16'h0003);
      rd(ctrl_pkg::ENABLE_ADDR);
      chk(got, 16'h0003);
      wr(ctrl_pkg::ENABLE_ADDR, 16'h0001);
      rd(ctrl_pkg::ENABLE_ADDR);
      chk(got, 16'h0003);
      pulse_done();
      for (n = 0; n < 20 && stop_req !== 1'b1; n++) cyc(1);
      limit(n);
      chk(stop_req, 1'b1);
      @(posedge clk);
      master_busy <= 1'b0;
      for (n = 0; n < 20 && raw[ctrl_pkg::TX_ABRT_BIT] !== 1'b1; n++) cyc(1);
      limit(n);
      chk({stop_req, tx_flush}, 2'b01);
      rd(ctrl_pkg::ENABLE_ADDR);
      chk(got, 16'h0001);
      rd(ctrl_pkg::TXABRT_CLR_ADDR);
      chk({got[14:0], src_clear}, 16'h0003);
      cyc(3);
      chk({raw[ctrl_pkg::TX_ABRT_BIT], tx_flush}, 2'b00);
      done("abort");
      u_bus.send_start();
      for (n = 0; n < 20 && raw[ctrl_pkg::START_BIT] !== 1'b1; n++) cyc(1);
      limit(n);
      rd(ctrl_pkg::START_CLR_ADDR);
      chk(got, 16'h0001);
      cyc(2);
      chk(raw, 12'h000);
      @(posedge clk);
      bcast <= 1'b1;
      @(posedge clk);
      bcast <= 1'b0;
      cyc(2);
      chk(raw[ctrl_pkg::GCALL_BIT], 1'b1);
      rd(ctrl_pkg::GCALL_CLR_ADDR);
      chk(got, 16'h0001);
      cyc(2);
      chk(raw, 12'h000);
      done("start and general call");
      u_bus.send_stop();
      for (n = 0; n < 20 && raw[ctrl_pkg::STOP_BIT] !== 1'b1; n++) cyc(1);
      limit(n);
      @(posedge clk);
      slave_busy <= 1'b1;
      receiving <= 1'b1;
      wr(ctrl_pkg::ENABLE_ADDR, 16'h0000);
      cyc(6);
      chk({masked[ctrl_pkg::STOP_BIT], rx_nack, enabled}, 3'b110);
      @(posedge clk);
      slave_busy <= 1'b0;
      receiving <= 1'b0;
      cyc(3);
      chk(masked, 12'h000);
      rd(ctrl_pkg::STOP_CLR_ADDR);
      chk(got, 16'h0001);
      cyc(2);
      chk(raw, 12'h000);
      done("stop and disable while receiving");
      @(posedge clk);
      master_busy <= 1'b1;
      wr(ctrl_pkg::ENABLE_ADDR, 16'h0001);
      cyc(4);
      wr(ctrl_pkg::ENABLE_ADDR, 16'h0000);
      cyc(1);
      chk(enabled, 1'b1);
      cyc(1);
      chk(enabled, 1'b0);
      cyc(3);
      chk(tx_flush, 1'b0);
      pulse_done();
      cyc(3);
      chk(stop_req, 1'b1);
      @(posedge clk);
      master_busy <= 1'b0;
      cyc(3);
      chk({tx_flush, rx_flush}, 2'b11);
      done("disable while transmitting");
      report_and_stop();
   end
endmodule
